/* logic/rtc_alarm_pkg.sv */
// constants and types shared by the calendar alarm block
package rtc_alarm_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_FIELDS = 6;
    localparam int unsigned TGT_W = 7;

    // register offsets
    localparam logic [7:0] OFS_SECOND_ALARM  = 8'h00;
    localparam logic [7:0] OFS_MINUTE_ALARM  = 8'h04;
    localparam logic [7:0] OFS_HOUR_ALARM    = 8'h08;
    localparam logic [7:0] OFS_WEEKDAY_ALARM = 8'h0C;
    localparam logic [7:0] OFS_DATE_ALARM    = 8'h10;
    localparam logic [7:0] OFS_MONTH_ALARM   = 8'h14;
    localparam logic [7:0] OFS_ALARM_CTRL    = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h20;
    localparam logic [7:0] OFS_MATCH_STATE   = 8'h24;

    // field indices, also the order of the alarm registers
    localparam int unsigned FLD_SEC   = 0;
    localparam int unsigned FLD_MIN   = 1;
    localparam int unsigned FLD_HOUR  = 2;
    localparam int unsigned FLD_WDAY  = 3;
    localparam int unsigned FLD_DATE  = 4;
    localparam int unsigned FLD_MONTH = 5;

    // alarm register layout
    localparam int unsigned ENABLE_BIT = 7;

    // writable target bits per alarm register, reserved bits clear
    localparam logic [6:0] TGT_MASK_SEC   = 7'h7F;
    localparam logic [6:0] TGT_MASK_MIN   = 7'h7F;
    localparam logic [6:0] TGT_MASK_HOUR  = 7'h3F;
    localparam logic [6:0] TGT_MASK_WDAY  = 7'h07;
    localparam logic [6:0] TGT_MASK_DATE  = 7'h3F;
    localparam logic [6:0] TGT_MASK_MONTH = 7'h1F;

    // alarm control register layout
    localparam int unsigned CTRL_FLAG_BIT = 0;
    localparam int unsigned CTRL_AIE_BIT  = 3;

    // interrupt status and mask layout
    localparam int unsigned IRQ_BITS        = 2;
    localparam int unsigned IRQ_MATCH_BIT   = 0;
    localparam int unsigned IRQ_RELEASE_BIT = 1;

    // match state register layout
    localparam int unsigned STATE_MATCH_BIT = 7;

    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // calendar counters, BCD, reserved bits left out
    typedef struct packed {
        logic [4:0] month;
        logic [5:0] date;
        logic [2:0] weekday;
        logic [5:0] hour;
        logic [6:0] minute;
        logic [6:0] second;
    } calendar_s;

    // one alarm register as kept in flops
    typedef struct packed {
        logic       enable;
        logic [6:0] target;
    } alarm_reg_s;

endpackage : rtc_alarm_pkg

/* logic/alarm_field_cmp.sv */
// one alarm field against its calendar counter
`timescale 1ns/1ps
module alarm_field_cmp (
    // field setting
    input  wire logic       enable,
    input  wire logic [6:0] target,
    input  wire logic [6:0] valid_mask,
    // live counter value
    input  wire logic [6:0] counter,
    // result
    output logic            hit
);

    // a disabled field never blocks the match
    assign hit = !enable || ((target & valid_mask) == (counter & valid_mask));

endmodule : alarm_field_cmp

/* logic/rtc_alarm_match.sv */
// calendar alarm registers, field compare, alarm flag and interrupt
//
// Notes on behaviour
// - seconds compared only while its enable set
// - minutes compared only while its enable set
// - hours compared when enabled; bit 6 zero
// - weekday compared when enabled; bits 6-3 zero
// - date compared when enabled; bit 6 zero
// - month compared when enabled; bits 6-5 zero
// - alarm needs all enabled fields equal
// - power-on clears enables, keeps targets
// - manual reset and standby keep alarm registers
// - match sets flag; write 0 clears
// - flag reaches interrupt only with enable bit
`timescale 1ns/1ps
module rtc_alarm_match (
    // clock and resets
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        manual_rst,
    // register port
    input  wire logic [7:0]                  addr,
    input  wire logic [7:0]                  wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [7:0]                  rdata,
    // calendar counters
    input  wire rtc_alarm_pkg::calendar_s    calendar,
    // alarm outputs
    output logic                             alarm_event,
    output logic                             alarm_irq,
    output logic                             irq
);

    localparam int unsigned NF = rtc_alarm_pkg::NUM_FIELDS;
    localparam int unsigned EB = rtc_alarm_pkg::ENABLE_BIT;
    localparam int unsigned TW = rtc_alarm_pkg::TGT_W;

    // per field writable target bits
    localparam logic [NF-1:0][6:0] TGT_MASK = {
        rtc_alarm_pkg::TGT_MASK_MONTH,
        rtc_alarm_pkg::TGT_MASK_DATE,
        rtc_alarm_pkg::TGT_MASK_WDAY,
        rtc_alarm_pkg::TGT_MASK_HOUR,
        rtc_alarm_pkg::TGT_MASK_MIN,
        rtc_alarm_pkg::TGT_MASK_SEC
    };

    // per field register offset
    localparam logic [NF-1:0][7:0] FLD_OFS = {
        rtc_alarm_pkg::OFS_MONTH_ALARM,
        rtc_alarm_pkg::OFS_DATE_ALARM,
        rtc_alarm_pkg::OFS_WEEKDAY_ALARM,
        rtc_alarm_pkg::OFS_HOUR_ALARM,
        rtc_alarm_pkg::OFS_MINUTE_ALARM,
        rtc_alarm_pkg::OFS_SECOND_ALARM
    };

    // alarm register state
    logic [NF-1:0]      enable_q;
    logic [NF-1:0][6:0] target_q;
    logic [NF-1:0]      fld_wr;
    logic [NF-1:0][6:0] counter_fld;
    logic [NF-1:0]      hit;

    // control and interrupt state
    logic                                   flag_q;
    logic                                   aie_q;
    logic [rtc_alarm_pkg::IRQ_BITS-1:0]     status_q;
    logic [rtc_alarm_pkg::IRQ_BITS-1:0]     mask_q;
    logic [rtc_alarm_pkg::IRQ_BITS-1:0]     status_set;
    logic [rtc_alarm_pkg::IRQ_BITS-1:0]     status_clr;

    // match tracking
    logic                                   match_now;
    logic                                   match_q;
    logic                                   match_rise;
    logic                                   match_fall;
    logic                                   any_enabled;

    // register decode
    logic                                   ctrl_wr;
    logic                                   status_wr;
    logic                                   mask_wr;
    logic [7:0]                             rdata_d;

    // counters spread into the field order of the registers
    assign counter_fld[rtc_alarm_pkg::FLD_SEC]   = calendar.second;
    assign counter_fld[rtc_alarm_pkg::FLD_MIN]   = calendar.minute;
    assign counter_fld[rtc_alarm_pkg::FLD_HOUR]  = {1'b0, calendar.hour};
    assign counter_fld[rtc_alarm_pkg::FLD_WDAY]  = {4'h0, calendar.weekday};
    assign counter_fld[rtc_alarm_pkg::FLD_DATE]  = {1'b0, calendar.date};
    assign counter_fld[rtc_alarm_pkg::FLD_MONTH] = {2'h0, calendar.month};

    assign ctrl_wr   = wr_en && (addr == rtc_alarm_pkg::OFS_ALARM_CTRL);
    assign status_wr = wr_en && (addr == rtc_alarm_pkg::OFS_IRQ_STATUS);
    assign mask_wr   = wr_en && (addr == rtc_alarm_pkg::OFS_IRQ_MASK);

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_field
            assign fld_wr[gi] = wr_en && (addr == FLD_OFS[gi]);

            // enable bit cleared by power-on reset or by a write with the enable bit 0, not by manual reset
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    enable_q[gi] <= 1'b0;
                end else if (fld_wr[gi]) begin
                    enable_q[gi] <= wdata[EB];
                end
            end

            // targets have no reset at all, so no reset can disturb them
            always_ff @(posedge clk) begin
                if (fld_wr[gi]) begin
                    target_q[gi] <= wdata[TW-1:0] & TGT_MASK[gi];
                end
            end

            alarm_field_cmp u_cmp (
                .enable     (enable_q[gi]),
                .target     (target_q[gi]),
                .valid_mask (TGT_MASK[gi]),
                .counter    (counter_fld[gi]),
                .hit        (hit[gi])
            );
        end
    endgenerate

    // all enables clear would match forever, so that counts as no alarm
    assign any_enabled = |enable_q;
    assign match_now   = any_enabled && (&hit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_now;
        end
    end

    // one event per entry into the matching state
    assign match_rise  = match_now && !match_q;
    assign match_fall  = !match_now && match_q;
    assign alarm_event = match_rise;

    // alarm flag: set wins over a clearing write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (match_rise) begin
            flag_q <= 1'b1;
        end else if (manual_rst) begin
            flag_q <= 1'b0;
        end else if (ctrl_wr && !wdata[rtc_alarm_pkg::CTRL_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aie_q <= 1'b0;
        end else if (manual_rst) begin
            aie_q <= 1'b0;
        end else if (ctrl_wr) begin
            aie_q <= wdata[rtc_alarm_pkg::CTRL_AIE_BIT];
        end
    end

    assign alarm_irq = flag_q && aie_q;

    // sticky interrupt status, write one to clear, set wins
    assign status_set = {match_fall, match_rise};
    assign status_clr = status_wr ? wdata[rtc_alarm_pkg::IRQ_BITS-1:0]
                                  : {rtc_alarm_pkg::IRQ_BITS{1'b0}};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= status_set | (status_q & ~status_clr);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= '0;
        end else if (mask_wr) begin
            mask_q <= wdata[rtc_alarm_pkg::IRQ_BITS-1:0];
        end
    end

    // the mask gates status; the alarm flag path keeps its own enable
    assign irq = alarm_irq || (|(status_q & mask_q));

    // read mux, unmapped offsets read zero
    always_comb begin
        rdata_d = rtc_alarm_pkg::ZERO_BYTE;
        for (int i = 0; i < NF; i++) begin
            if (addr == FLD_OFS[i]) begin
                rdata_d = {enable_q[i], target_q[i]};
            end
        end
        case (addr)
            rtc_alarm_pkg::OFS_ALARM_CTRL: begin
                rdata_d[rtc_alarm_pkg::CTRL_FLAG_BIT] = flag_q;
                rdata_d[rtc_alarm_pkg::CTRL_AIE_BIT]  = aie_q;
            end
            rtc_alarm_pkg::OFS_IRQ_STATUS: begin
                rdata_d[rtc_alarm_pkg::IRQ_BITS-1:0] = status_q;
            end
            rtc_alarm_pkg::OFS_IRQ_MASK: begin
                rdata_d[rtc_alarm_pkg::IRQ_BITS-1:0] = mask_q;
            end
            rtc_alarm_pkg::OFS_MATCH_STATE: begin
                rdata_d[NF-1:0] = hit & enable_q;
                rdata_d[rtc_alarm_pkg::STATE_MATCH_BIT] = match_now;
            end
            default: begin
                rdata_d = rdata_d;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= rtc_alarm_pkg::ZERO_BYTE;
        end else if (rd_en) begin
            rdata <= rdata_d;
        end else begin
            rdata <= rtc_alarm_pkg::ZERO_BYTE;
        end
    end

endmodule : rtc_alarm_match

/* verification/rtc_alarm_match_chk.sv */
// concurrent checks on the port behaviour of the calendar alarm block
`timescale 1ns/1ps
module rtc_alarm_match_chk (
    // clock and resets
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     manual_rst,
    // register port
    input  wire logic [7:0]               addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [7:0]               rdata,
    // calendar and alarm outputs
    input  wire rtc_alarm_pkg::calendar_s calendar,
    input  wire logic                     alarm_event,
    input  wire logic                     alarm_irq,
    input  wire logic                     irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_of(logic [7:0] a);
        rd_en && addr == a;
    endsequence

    event_once_a: assert property (alarm_event |=> !alarm_event)
        else $error("alarm event lasted past one cycle");
    event_cause_a: assert property (alarm_event |->
        $past(wr_en) || $past(calendar) != calendar)
        else $error("alarm event without a new match");
    rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside a read");
    hour_rsvd_a: assert property (rd_of(rtc_alarm_pkg::OFS_HOUR_ALARM) |=> !rdata[6])
        else $error("hour reserved bit read high");
    wday_rsvd_a: assert property (rd_of(rtc_alarm_pkg::OFS_WEEKDAY_ALARM)
        |=> rdata[6:3] == 4'h0)
        else $error("weekday reserved bits read high");
    date_rsvd_a: assert property (rd_of(rtc_alarm_pkg::OFS_DATE_ALARM) |=> !rdata[6])
        else $error("date reserved bit read high");
    month_rsvd_a: assert property (rd_of(rtc_alarm_pkg::OFS_MONTH_ALARM)
        |=> rdata[6:5] == 2'h0)
        else $error("month reserved bits read high");
    irq_rise_a: assert property ($rose(alarm_irq) |->
        $past(alarm_event) || $past(wr_en))
        else $error("alarm interrupt rose without cause");
    irq_hold_a: assert property (alarm_irq && !manual_rst
        && !(wr_en && addr == rtc_alarm_pkg::OFS_ALARM_CTRL) |=> alarm_irq)
        else $error("alarm interrupt dropped without clear");
    irq_merge_a: assert property (alarm_irq |-> irq)
        else $error("alarm interrupt missing on irq");
endmodule : rtc_alarm_match_chk

bind rtc_alarm_match rtc_alarm_match_chk u_rtc_alarm_match_chk (.clk(clk), .rst(rst),
    .manual_rst(manual_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .calendar(calendar), .alarm_event(alarm_event), .alarm_irq(alarm_irq),
    .irq(irq));

/* verification/testbench.sv */
// self-checking bench for the calendar alarm block
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    logic                     clk;
    logic                     rst;
    logic                     manual_rst;
    logic [7:0]               addr;
    logic [7:0]               wdata;
    logic                     wr_en;
    logic                     rd_en;
    logic [7:0]               rdata;
    rtc_alarm_pkg::calendar_s calendar;
    logic                     alarm_event;
    logic                     alarm_irq;
    logic                     irq;
    int                       n_mismatch;
    int                       tests_run;
    int                       n_event;
    logic [7:0]               ofs [6];
    logic [6:0]               msk [6];
    logic [6:0]               val [6];
    logic [6:0]               hi_val [6];

    rtc_alarm_match u_rtc_alarm_match (.clk(clk), .rst(rst), .manual_rst(manual_rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .calendar(calendar), .alarm_event(alarm_event), .alarm_irq(alarm_irq), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // sampled mid-cycle so the combinational pulse has settled
    always @(negedge clk) if (alarm_event === 1'b1) n_event++;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask : rd_chk

    task automatic give_verdict();
        $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #100us;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        manual_rst = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        calendar = '0;
        n_mismatch = 0;
        tests_run = 0;
        n_event = 0;
        ofs = '{rtc_alarm_pkg::OFS_SECOND_ALARM, rtc_alarm_pkg::OFS_MINUTE_ALARM,
                rtc_alarm_pkg::OFS_HOUR_ALARM, rtc_alarm_pkg::OFS_WEEKDAY_ALARM,
                rtc_alarm_pkg::OFS_DATE_ALARM, rtc_alarm_pkg::OFS_MONTH_ALARM};
        msk = '{7'h7F, 7'h7F, 7'h3F, 7'h07, 7'h3F, 7'h1F};
        val = '{7'h30, 7'h15, 7'h08, 7'h03, 7'h21, 7'h11};
        hi_val = '{7'h59, 7'h59, 7'h23, 7'h06, 7'h31, 7'h12};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        calendar <= '{month: 5'h11, date: 6'h21, weekday: 3'h3, hour: 6'h08,
                      minute: 7'h15, second: 7'h30};
        // highest legal targets never meet this calendar, so no alarm here
        // reserved bits are written high so the reads show them ignored
        for (int i = 0; i < 6; i++) wr(ofs[i], {1'b1, hi_val[i] | ~msk[i]});
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], {1'b1, hi_val[i]});
        @(posedge clk) manual_rst <= 1'b1;
        @(posedge clk) manual_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], {1'b1, hi_val[i]});
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], {1'b0, hi_val[i]});
        wr(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h08);
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], {1'b1, val[i] ^ 7'h01});
            wr(ofs[i], {1'b1, val[i]});
            repeat (2) @(posedge clk);
            `CHK(n_event, i + 1)
            wr(ofs[i], 8'h00);
        end
        `CHK(alarm_irq, 1'b1)
        rd_chk(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h09);
        wr(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h09);
        `CHK(alarm_irq, 1'b1)
        wr(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h01);
        `CHK(alarm_irq, 1'b0)
        wr(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h00);
        rd_chk(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h00);
        rd_chk(rtc_alarm_pkg::OFS_IRQ_STATUS, 8'h03);
        wr(rtc_alarm_pkg::OFS_IRQ_MASK, 8'h01);
        `CHK(irq, 1'b1)
        wr(rtc_alarm_pkg::OFS_IRQ_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        rd_chk(rtc_alarm_pkg::OFS_IRQ_STATUS, 8'h02);
        rd_chk(8'h3C, 8'h00);
        // disabled fields are left mismatching on purpose
        wr(rtc_alarm_pkg::OFS_MINUTE_ALARM, 8'h01);
        wr(rtc_alarm_pkg::OFS_SECOND_ALARM, 8'hB0);
        wr(rtc_alarm_pkg::OFS_HOUR_ALARM, 8'h89);
        repeat (2) @(posedge clk);
        `CHK(n_event, 7)
        @(posedge clk) calendar.hour <= 6'h09;
        repeat (3) @(posedge clk);
        #1;
        `CHK(n_event, 8)
        `CHK(irq, 1'b1)
        // second and hour enabled and hitting, full match bit set
        rd_chk(rtc_alarm_pkg::OFS_MATCH_STATE, 8'h85);
        wr(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h09);
        `CHK(alarm_irq, 1'b1)
        @(posedge clk) manual_rst <= 1'b1;
        @(posedge clk) manual_rst <= 1'b0;
        #1;
        `CHK(alarm_irq, 1'b0)
        rd_chk(rtc_alarm_pkg::OFS_ALARM_CTRL, 8'h00);
        give_verdict();
    end
endmodule : testbench
